// ===== itod_defs.vh
// Constants for the instruction timing and operand decode block.
// Assumes it is included by bare name from each design file.
`ifndef ITOD_DEFS_VH
`define ITOD_DEFS_VH

// Instruction classes supplied by the predecoder.
`define ITOD_CL_SINGLE 4'h0
`define ITOD_CL_BRCOND 4'h1
`define ITOD_CL_BRLONG 4'h2
`define ITOD_CL_SKIP 4'h3
`define ITOD_CL_DMOVE 4'h4
`define ITOD_CL_TWOWORD 4'h5
`define ITOD_CL_FILE 4'h6
`define ITOD_CL_DSP 4'h7

// Word and instruction sizes.
`define ITOD_WORD_W 24
`define ITOD_INSTR_W 48
`define ITOD_W2_HI 23
`define ITOD_W2_LO 16

// Cycle counts.
`define ITOD_CYC_ONE 2'h1
`define ITOD_CYC_TWO 2'h2
`define ITOD_CYC_THREE 2'h3

// Operand field positions within the first word.
`define ITOD_F_ACC 15
`define ITOD_F_WB_HI 1
`define ITOD_F_WB_LO 0
`define ITOD_F_XPF_LO 2
`define ITOD_F_YPF_LO 6
`define ITOD_F_XD_LO 10
`define ITOD_F_YD_LO 12
`define ITOD_F_MUL_HI 18
`define ITOD_F_MUL_LO 16
`define ITOD_F_SQR 19
`define ITOD_F_BIT_HI 3
`define ITOD_F_BIT_LO 0
`define ITOD_F_LIT_HI 13
`define ITOD_F_LIT_LO 4
`define ITOD_F_BYTE 14
`define ITOD_F_REG_HI 3
`define ITOD_F_REG_LO 0

// Operand values.
`define ITOD_WB_NONE 2'h0
`define ITOD_WB_DIRECT 2'h1
`define ITOD_WB_POSTINC 2'h2
`define ITOD_WB_STEP 4'h2
`define ITOD_REG_W0 4'h0
`define ITOD_REG_W4 4'h4
`define ITOD_REG_W8 4'h8
`define ITOD_REG_W10 4'ha
`define ITOD_REG_W12 4'hc
`define ITOD_REG_W13 4'hd
`define ITOD_PF_IDX 4'he
`define ITOD_PF_NONE 4'hf
`define ITOD_PF_HALF 4'h7
`define ITOD_LIT_BYTE_MAX 10'h0ff

`endif

// ===== itod_opd.v
// Operand field decoder for DSP, bit, literal and register operands.
// Assumes a combinational consumer on the same clock; registered by the parent.
`timescale 1ns/1ps
`default_nettype none
`include "itod_defs.vh"

module itod_opd (
    input wire [47:0] instr,
    input wire [3:0] iclass,
    output reg acc_b,
    output reg [3:0] wb_reg,
    output reg wb_en,
    output reg [3:0] wb_step,
    output wire [3:0] bit_index_field,
    output wire [9:0] ten_bit_literal,
    output reg lit_ok,
    output reg [3:0] any_work_register,
    output wire [1:0] pf_en,
    output wire [7:0] pf_reg,
    output wire [7:0] pf_step,
    output wire [1:0] pf_idx,
    output wire [7:0] pf_dst,
    output reg [3:0] mul_a,
    output reg [3:0] mul_b,
    output reg dsp_ok
);

    // ------------------------------------------------------------
    // Plain fields
    // ------------------------------------------------------------
    wire [2:0] mul_code = instr[`ITOD_F_MUL_HI:`ITOD_F_MUL_LO];
    wire [1:0] wb_code = instr[`ITOD_F_WB_HI:`ITOD_F_WB_LO];
    assign bit_index_field = instr[`ITOD_F_BIT_HI:`ITOD_F_BIT_LO];
    assign ten_bit_literal = instr[`ITOD_F_LIT_HI:`ITOD_F_LIT_LO];
    reg mul_ok;

    always @* begin
        acc_b = instr[`ITOD_F_ACC];
        lit_ok = !(instr[`ITOD_F_BYTE] && (ten_bit_literal > `ITOD_LIT_BYTE_MAX));
        if (iclass == `ITOD_CL_FILE) begin
            any_work_register = `ITOD_REG_W0;
        end else begin
            any_work_register = instr[`ITOD_F_REG_HI:`ITOD_F_REG_LO];
        end
        wb_reg = `ITOD_REG_W13;
        wb_en = (wb_code == `ITOD_WB_DIRECT) || (wb_code == `ITOD_WB_POSTINC);
        wb_step = (wb_code == `ITOD_WB_POSTINC) ? `ITOD_WB_STEP : 4'h0;
        mul_ok = 1'b1;
        if (instr[`ITOD_F_SQR]) begin
            mul_a = `ITOD_REG_W4 + {2'h0, mul_code[1:0]};
            mul_b = mul_a;
        end else begin
            case (mul_code)
                3'h0: begin mul_a = 4'h4; mul_b = 4'h5; end
                3'h1: begin mul_a = 4'h4; mul_b = 4'h6; end
                3'h2: begin mul_a = 4'h4; mul_b = 4'h7; end
                3'h3: begin mul_a = 4'h5; mul_b = 4'h6; end
                3'h4: begin mul_a = 4'h5; mul_b = 4'h7; end
                3'h5: begin mul_a = 4'h6; mul_b = 4'h7; end
                default: begin mul_a = 4'h4; mul_b = 4'h5; mul_ok = 1'b0; end
            endcase
        end
        dsp_ok = mul_ok && (wb_code != 2'h3);
    end

    // ------------------------------------------------------------
    // Prefetch decode, X space at index 0 and Y space at index 1
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_pf
            wire [3:0] code = instr[`ITOD_F_XPF_LO + 4 * g +: 4];
            wire [3:0] base = (g == 0) ? `ITOD_REG_W8 : `ITOD_REG_W10;
            wire hi = (code >= `ITOD_PF_HALF);
            wire [3:0] sub = hi ? (code - `ITOD_PF_HALF) : code;
            reg [3:0] step;
            always @* begin
                case (sub[2:0])
                    3'h0: step = 4'h6;
                    3'h1: step = 4'h4;
                    3'h2: step = 4'h2;
                    3'h4: step = 4'ha;
                    3'h5: step = 4'hc;
                    3'h6: step = 4'he;
                    default: step = 4'h0;
                endcase
            end
            assign pf_en[g] = (code != `ITOD_PF_NONE);
            assign pf_idx[g] = (code == `ITOD_PF_IDX);
            assign pf_reg[4 * g +: 4] = base + {3'h0, hi};
            assign pf_step[4 * g +: 4] = (code >= `ITOD_PF_IDX) ? 4'h0 : step;
            assign pf_dst[4 * g +: 4] =
                `ITOD_REG_W4 + {2'h0, instr[`ITOD_F_XD_LO + 2 * g +: 2]};
        end
    endgenerate

endmodule // itod_opd
`default_nettype wire

// ===== itod_props.sv
// Concurrent checks on the ports of the instruction timing and operand decode top.
// Assumes one clock, mclk, with a synchronous active-high rst; checks are disabled in any cycle with ce low.
`timescale 1ns/1ps
`default_nettype none

module itod_props (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic iw_valid,
    input wire logic [23:0] iw_word,
    input wire logic [3:0] iw_class,
    input wire logic cond_true,
    input wire logic pc_change,
    input wire logic extra_cycle,
    input wire logic skip_next_two,
    input wire logic iw_ready_q,
    input wire logic ex_valid_q,
    input wire logic ex_nop_q,
    input wire logic ex_lone_q,
    input wire logic ex_bad_q,
    input wire logic [1:0] ex_cycles_q,
    input wire logic [47:0] ex_instr_q,
    input wire logic ex_two_q,
    input wire logic [3:0] ex_wb_reg_q,
    input wire logic ex_wb_en_q,
    input wire logic [3:0] ex_wb_step_q,
    input wire logic ex_lit_ok_q,
    input wire logic [3:0] ex_work_reg_q,
    input wire logic [3:0] ex_mul_a_q,
    input wire logic [3:0] ex_mul_b_q,
    input wire logic ex_dsp_ok_q
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    // The pairing flag mirrors the fetch side so word order can be judged.
    logic take, hi_zero, pend_q, pend_d, full_q;
    logic [1:0] cyc_d, cyc_q;
    logic [23:0] w_q;
    logic [3:0] cls_q;
    assign take = ce && iw_valid && iw_ready_q;
    assign hi_zero = (iw_word[23:16] == 8'h00);
    always @* begin
        case (iw_class)
            4'h1: cyc_d = cond_true ? 2'h2 : 2'h1;
            4'h2: cyc_d = extra_cycle ? 2'h3 : 2'h2;
            4'h3: cyc_d = cond_true ? (skip_next_two ? 2'h3 : 2'h2) : 2'h1;
            4'h4: cyc_d = 2'h2;
            default: cyc_d = (cond_true || pc_change) ? 2'h2 : 2'h1;
        endcase
        pend_d = rst ? 1'b0 : (take ? (!pend_q && iw_class == 4'h5 && !hi_zero) : pend_q);
    end
    always @(posedge mclk) begin
        pend_q <= pend_d;
        full_q <= take && !pend_q && !hi_zero && iw_class != 4'h5;
        cyc_q <= cyc_d;
        w_q <= iw_word;
        cls_q <= iw_class;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (rst || !ce);

    chk_lone_nop: assert property (take && !pend_q && hi_zero |=>
        ex_valid_q && ex_lone_q && !ex_two_q && ex_cycles_q == 2'h1) else $error("lone word");
    chk_pair_join: assert property (take && pend_q |=> ex_valid_q && ex_two_q &&
        ex_cycles_q == 2'h2 && ex_instr_q[47:24] == w_q) else $error("pair join");
    chk_first_quiet: assert property (take && !pend_q && !hi_zero && iw_class == 4'h5
        |=> !ex_valid_q && iw_ready_q) else $error("first word issued");
    chk_cycle_count: assert property (full_q |->
        ex_valid_q && ex_cycles_q == cyc_q) else $error("cycle count");
    chk_nop_pad: assert property (ex_valid_q && ex_cycles_q == 2'h3 |-> !iw_ready_q
        ##1 (ex_nop_q && !iw_ready_q) ##1 ex_nop_q ##1 !ex_nop_q) else $error("nop pad");
    chk_ready_gap: assert property (ex_valid_q && ex_cycles_q == 2'h2 |->
        !iw_ready_q ##1 (ex_nop_q && iw_ready_q)) else $error("ready gap");
    chk_wb_fixed: assert property (ex_valid_q && !ex_lone_q |-> ex_wb_reg_q == 4'hd &&
        ex_wb_en_q == (ex_instr_q[1:0] == 2'h1 || ex_instr_q[1:0] == 2'h2) &&
        ex_wb_step_q == (ex_instr_q[1:0] == 2'h2 ? 4'h2 : 4'h0)) else $error("writeback");
    chk_work_pick: assert property (full_q |->
        ex_work_reg_q == (cls_q == 4'h6 ? 4'h0 : w_q[3:0])) else $error("work register");
    chk_lit_flag: assert property (ex_valid_q && !ex_lone_q |->
        ex_lit_ok_q == !(ex_instr_q[14] && ex_instr_q[13:4] > 10'h0ff)) else $error("literal");
    chk_mul_pair: assert property (ex_valid_q && ex_dsp_ok_q && !ex_instr_q[19] |->
        ex_mul_a_q >= 4'h4 && ex_mul_b_q > ex_mul_a_q && ex_mul_b_q <= 4'h7) else $error("pair");
    chk_square_same: assert property (ex_valid_q && ex_dsp_ok_q && ex_instr_q[19] |->
        ex_mul_a_q == ex_mul_b_q && ex_mul_a_q == {2'b01, ex_instr_q[17:16]}) else $error("square");

    cover property (ex_valid_q && ex_cycles_q == 2'h3);
    cover property (ex_valid_q && ex_two_q && ex_bad_q);
    cover property (ex_valid_q && ex_lone_q);
endmodule // itod_props

`default_nettype wire

// ===== itod_top.v
// Instruction timing sequencer with registered operand decode.
// Assumes the fetch stage supplies words, a predecoded class and
// condition results on mclk, and holds a word until ready is seen.
`timescale 1ns/1ps
`default_nettype none
`include "itod_defs.vh"

module itod_top (
    input wire mclk,
    input wire rst,
    input wire ce,
    input wire iw_valid,
    input wire [23:0] iw_word,
    input wire [3:0] iw_class,
    input wire cond_true,
    input wire pc_change,
    input wire extra_cycle,
    input wire skip_next_two,
    output reg iw_ready_q,
    output reg ex_valid_q,
    output reg ex_nop_q,
    output reg ex_lone_q,
    output reg ex_bad_q,
    output reg [1:0] ex_cycles_q,
    output reg [47:0] ex_instr_q,
    output reg ex_two_q,
    output reg ex_acc_b_q,
    output reg [3:0] ex_wb_reg_q,
    output reg ex_wb_en_q,
    output reg [3:0] ex_wb_step_q,
    output reg [3:0] ex_bit_q,
    output reg [9:0] ex_lit_q,
    output reg ex_lit_ok_q,
    output reg [3:0] ex_work_reg_q,
    output reg [1:0] ex_pf_en_q,
    output reg [7:0] ex_pf_reg_q,
    output reg [7:0] ex_pf_step_q,
    output reg [1:0] ex_pf_idx_q,
    output reg [7:0] ex_pf_dst_q,
    output reg [3:0] ex_mul_a_q,
    output reg [3:0] ex_mul_b_q,
    output reg ex_dsp_ok_q
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WORD2 = 2'h1;
    localparam [1:0] ST_BUSY = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [1:0] cnt_q;
    reg [1:0] cnt_d;
    reg [23:0] w1_q;
    reg [3:0] cls_q;
    reg issue;
    reg lone;
    reg bad;
    reg two;
    reg [1:0] cyc;
    reg [47:0] instr_d;
    reg [3:0] cls_d;

    wire take = iw_valid && iw_ready_q;
    wire upper_zero = (iw_word[`ITOD_W2_HI:`ITOD_W2_LO] == 8'h00);

    // ------------------------------------------------------------
    // Operand decode
    // ------------------------------------------------------------
    wire o_acc_b;
    wire [3:0] o_wb_reg;
    wire o_wb_en;
    wire [3:0] o_wb_step;
    wire [3:0] o_bit;
    wire [9:0] o_lit;
    wire o_lit_ok;
    wire [3:0] o_work_reg;
    wire [1:0] o_pf_en;
    wire [7:0] o_pf_reg;
    wire [7:0] o_pf_step;
    wire [1:0] o_pf_idx;
    wire [7:0] o_pf_dst;
    wire [3:0] o_mul_a;
    wire [3:0] o_mul_b;
    wire o_dsp_ok;

    itod_opd i_itod_opd (
        .instr(instr_d),
        .iclass(cls_d),
        .acc_b(o_acc_b),
        .wb_reg(o_wb_reg),
        .wb_en(o_wb_en),
        .wb_step(o_wb_step),
        .bit_index_field(o_bit),
        .ten_bit_literal(o_lit),
        .lit_ok(o_lit_ok),
        .any_work_register(o_work_reg),
        .pf_en(o_pf_en),
        .pf_reg(o_pf_reg),
        .pf_step(o_pf_step),
        .pf_idx(o_pf_idx),
        .pf_dst(o_pf_dst),
        .mul_a(o_mul_a),
        .mul_b(o_mul_b),
        .dsp_ok(o_dsp_ok)
    );

    // ------------------------------------------------------------
    // Cycle count per class
    // ------------------------------------------------------------
    // The fetch stage resolves conditions and the width of the next
    // instruction; this block only turns them into a cycle count.
    always @* begin
        case (iw_class)
            `ITOD_CL_BRCOND: begin
                cyc = cond_true ? `ITOD_CYC_TWO : `ITOD_CYC_ONE;
            end
            `ITOD_CL_BRLONG: begin
                cyc = extra_cycle ? `ITOD_CYC_THREE : `ITOD_CYC_TWO;
            end
            `ITOD_CL_SKIP: begin
                if (cond_true) begin
                    cyc = skip_next_two ? `ITOD_CYC_THREE : `ITOD_CYC_TWO;
                end else begin
                    cyc = `ITOD_CYC_ONE;
                end
            end
            `ITOD_CL_DMOVE: begin
                cyc = `ITOD_CYC_TWO;
            end
            default: begin
                cyc = (cond_true || pc_change) ? `ITOD_CYC_TWO : `ITOD_CYC_ONE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        issue = 1'b0;
        lone = 1'b0;
        bad = 1'b0;
        two = 1'b0;
        instr_d = {24'h000000, iw_word};
        cls_d = iw_class;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    if (upper_zero) begin
                        issue = 1'b1;
                        lone = 1'b1;
                        cnt_d = 2'h0;
                    end else if (iw_class == `ITOD_CL_TWOWORD) begin
                        state_d = ST_WORD2;
                    end else begin
                        issue = 1'b1;
                        cnt_d = cyc - 2'h1;
                        if (cyc != `ITOD_CYC_ONE) begin
                            state_d = ST_BUSY;
                        end
                    end
                end
            end
            ST_WORD2: begin
                instr_d = {iw_word, w1_q};
                cls_d = cls_q;
                if (take) begin
                    issue = 1'b1;
                    two = 1'b1;
                    bad = !upper_zero;
                    cnt_d = `ITOD_CYC_TWO - 2'h1;
                    state_d = ST_BUSY;
                end
            end
            ST_BUSY: begin
                cnt_d = cnt_q - 2'h1;
                if (cnt_q == 2'h1) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d = 2'h0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Ready is registered from the next state, so a word offered in the
    // last stall cycle is taken in the next cycle, once ready is high, never dropped.
    always @(posedge mclk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 2'h0;
            w1_q <= 24'h000000;
            cls_q <= 4'h0;
            iw_ready_q <= 1'b0;
            ex_valid_q <= 1'b0;
            ex_nop_q <= 1'b0;
            ex_lone_q <= 1'b0;
            ex_bad_q <= 1'b0;
            ex_cycles_q <= 2'h0;
            ex_instr_q <= 48'h000000000000;
            ex_two_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            iw_ready_q <= (state_d != ST_BUSY);
            if (take && (state_q == ST_IDLE)) begin
                w1_q <= iw_word;
                cls_q <= iw_class;
            end
            ex_valid_q <= issue;
            ex_nop_q <= (state_q == ST_BUSY);
            if (issue) begin
                ex_lone_q <= lone;
                ex_bad_q <= bad;
                ex_two_q <= two;
                ex_cycles_q <= cnt_d + 2'h1;
                ex_instr_q <= instr_d;
            end
        end
    end

    // Operand outputs hold the last issued instruction until the next.
    always @(posedge mclk) begin
        if (rst) begin
            ex_acc_b_q <= 1'b0;
            ex_wb_reg_q <= 4'h0;
            ex_wb_en_q <= 1'b0;
            ex_wb_step_q <= 4'h0;
            ex_bit_q <= 4'h0;
            ex_lit_q <= 10'h000;
            ex_lit_ok_q <= 1'b0;
            ex_work_reg_q <= 4'h0;
            ex_pf_en_q <= 2'h0;
            ex_pf_reg_q <= 8'h00;
            ex_pf_step_q <= 8'h00;
            ex_pf_idx_q <= 2'h0;
            ex_pf_dst_q <= 8'h00;
            ex_mul_a_q <= 4'h0;
            ex_mul_b_q <= 4'h0;
            ex_dsp_ok_q <= 1'b0;
        end else if (ce && issue) begin
            ex_acc_b_q <= o_acc_b;
            ex_wb_reg_q <= o_wb_reg;
            ex_wb_en_q <= o_wb_en;
            ex_wb_step_q <= o_wb_step;
            ex_bit_q <= o_bit;
            ex_lit_q <= o_lit;
            ex_lit_ok_q <= o_lit_ok;
            ex_work_reg_q <= o_work_reg;
            ex_pf_en_q <= o_pf_en;
            ex_pf_reg_q <= o_pf_reg;
            ex_pf_step_q <= o_pf_step;
            ex_pf_idx_q <= o_pf_idx;
            ex_pf_dst_q <= o_pf_dst;
            ex_mul_a_q <= o_mul_a;
            ex_mul_b_q <= o_mul_b;
            ex_dsp_ok_q <= o_dsp_ok;
        end
    end

endmodule // itod_top
`default_nettype wire

// ===== itod_top_bench.sv
// Self-checking bench for the instruction timing and operand decode top.
// Assumes itod_defs.vh on the include path; drives the fetch side itself.
`timescale 1ns/1ps
`default_nettype none
`include "itod_defs.vh"

module itod_top_bench;
    typedef struct packed {
        logic [47:0] ins; logic [3:0] cls; logic [1:0] cyc; logic two, lone, bad;
    } itod_exp_t;
    logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, iw_valid = 1'b0;
    logic [23:0] iw_word = 24'h0;
    logic [3:0] iw_class = 4'h0;
    logic cond_true = 1'b0, pc_change = 1'b0, extra_cycle = 1'b0, skip_next_two = 1'b0;
    wire iw_ready_q, ex_valid_q, ex_nop_q, ex_lone_q, ex_bad_q, ex_two_q, ex_acc_b_q;
    wire ex_wb_en_q, ex_lit_ok_q, ex_dsp_ok_q;
    wire [1:0] ex_cycles_q, ex_pf_en_q, ex_pf_idx_q;
    wire [3:0] ex_wb_reg_q, ex_wb_step_q, ex_bit_q, ex_work_reg_q, ex_mul_a_q, ex_mul_b_q;
    wire [9:0] ex_lit_q;
    wire [7:0] ex_pf_reg_q, ex_pf_step_q, ex_pf_dst_q;
    wire [47:0] ex_instr_q;
    int err_total = 0, total_checks = 0;
    int nop_seen = 0, nop_exp = 0;
    logic ce_prev = 1'b1;
    itod_exp_t exp_q[$];
    logic [15:0] lf = 16'h33cf;
    logic pend = 1'b0;
    logic [23:0] w1;

    itod_top i_itod_top (.mclk, .rst, .ce, .iw_valid, .iw_word, .iw_class, .cond_true,
        .pc_change, .extra_cycle, .skip_next_two, .iw_ready_q, .ex_valid_q, .ex_nop_q,
        .ex_lone_q, .ex_bad_q, .ex_cycles_q, .ex_instr_q, .ex_two_q, .ex_acc_b_q,
        .ex_wb_reg_q, .ex_wb_en_q, .ex_wb_step_q, .ex_bit_q, .ex_lit_q, .ex_lit_ok_q,
        .ex_work_reg_q, .ex_pf_en_q, .ex_pf_reg_q, .ex_pf_step_q, .ex_pf_idx_q, .ex_pf_dst_q,
        .ex_mul_a_q, .ex_mul_b_q, .ex_dsp_ok_q);

    always #5 mclk = ~mclk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction

    task check(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task close_out;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Flags are {cond, pc change, extra cycle, skipped word is double}.
    function logic [1:0] cycles(input logic [3:0] c, input logic [3:0] f);
        case (c)
            4'h1: return f[3] ? 2'h2 : 2'h1;
            4'h2: return f[1] ? 2'h3 : 2'h2;
            4'h3: return f[3] ? (f[0] ? 2'h3 : 2'h2) : 2'h1;
            4'h4: return 2'h2;
            default: return (f[3] | f[2]) ? 2'h2 : 2'h1;
        endcase
    endfunction

    // Holds the word until ready is seen at an edge, then logs what must issue.
    task put(input logic [23:0] w, input logic [3:0] c, input logic [3:0] f);
        int n;
        iw_valid <= 1'b1;
        iw_word <= w;
        iw_class <= c;
        {cond_true, pc_change, extra_cycle, skip_next_two} <= f;
        n = 0;
        @(posedge mclk);
        while (iw_ready_q !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 20) err_total++;
        if (pend) begin
            exp_q.push_back('{{w, w1}, 4'h5, 2'h2, 1'b1, 1'b0, w[23:16] != 8'h00});
            pend = 1'b0;
        end else if (w[23:16] == 8'h00) begin
            exp_q.push_back('{{24'h0, w}, c, 2'h1, 1'b0, 1'b1, 1'b0});
        end else if (c == 4'h5) begin
            pend = 1'b1;
            w1 = w;
        end else begin
            exp_q.push_back('{{24'h0, w}, c, cycles(c, f), 1'b0, 1'b0, 1'b0});
        end
    endtask

    // ------------------------------------------------------------
    // Result monitor
    // ------------------------------------------------------------
    always @(posedge mclk) begin : mon
        itod_exp_t e;
        logic [3:0] c, m;
        logic [3:0] stp [7];
        logic [3:0] pa [6];
        logic [3:0] pb [6];
        stp = '{4'h6, 4'h4, 4'h2, 4'h0, 4'ha, 4'hc, 4'he};
        pa = '{4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6};
        pb = '{4'h5, 4'h6, 4'h7, 4'h6, 4'h7, 4'h7};
        // Outputs stay frozen across an edge with ce low, so each is counted once.
        ce_prev <= ce;
        if (!rst && ce_prev && ex_nop_q === 1'b1) nop_seen++;
        if (!rst && ce_prev && ex_valid_q === 1'b1) begin
            if (exp_q.size() == 0) e = '0;
            else e = exp_q.pop_front();
            nop_exp += e.cyc - 1;
            check(ex_cycles_q, e.cyc);
            check(ex_instr_q, e.ins);
            check(ex_two_q, e.two);
            check(ex_lone_q, e.lone);
            check(ex_bad_q, e.bad);
            if (!e.lone) begin
                check(ex_acc_b_q, e.ins[15]);
                check(ex_bit_q, e.ins[3:0]);
                check(ex_lit_q, e.ins[13:4]);
                check(ex_lit_ok_q, !(e.ins[14] && e.ins[13:4] > 10'h0ff));
                check(ex_work_reg_q, e.cls == 4'h6 ? 4'h0 : e.ins[3:0]);
                check(ex_wb_reg_q, 4'hd);
                check(ex_wb_en_q, e.ins[1:0] == 2'h1 || e.ins[1:0] == 2'h2);
                check(ex_wb_step_q, e.ins[1:0] == 2'h2 ? 4'h2 : 4'h0);
            end
            if (!e.lone && e.cls == 4'h7) begin
                for (int k = 0; k < 2; k++) begin
                    c = k ? e.ins[9:6] : e.ins[5:2];
                    check(ex_pf_en_q[k], c != 4'hf);
                    if (c != 4'hf) begin
                        check(ex_pf_reg_q[k*4+:4], (k ? 4'ha : 4'h8) + (c >= 4'h7));
                        check(ex_pf_idx_q[k], c == 4'he);
                        check(ex_pf_step_q[k*4+:4], c == 4'he ? 4'h0 : stp[c % 7]);
                        check(ex_pf_dst_q[k*4+:4], {2'b01, k ? e.ins[13:12] : e.ins[11:10]});
                    end
                end
                m = {1'b0, e.ins[18:16]};
                if (!e.ins[19]) begin
                    check(ex_dsp_ok_q, m < 4'h6 && e.ins[1:0] != 2'h3);
                    if (m < 4'h6 && e.ins[1:0] != 2'h3) begin
                        check(ex_mul_a_q, pa[m]);
                        check(ex_mul_b_q, pb[m]);
                    end
                end else begin
                    check(ex_dsp_ok_q, e.ins[1:0] != 2'h3);
                    check(ex_mul_a_q, {2'b01, e.ins[17:16]});
                    check(ex_mul_b_q, {2'b01, e.ins[17:16]});
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin : main
        logic [15:0] r, s, t;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        check(iw_ready_q, 1'b0);
        check(ex_valid_q, 1'b0);
        for (int i = 0; i < 400; i++) begin
            r = rnd();
            s = rnd();
            t = rnd();
            put({(s[1:0] == 2'b00) ? 8'h00 : s[15:8], t}, r[3:0], r[7:4]);
            if (pend) put({r[8] ? 8'h00 : s[15:8], t ^ r}, r[11:8], r[15:12]);
            if (r[14] && r[13]) begin
                iw_valid <= 1'b0;
                ce <= r[12];
                @(posedge mclk);
                ce <= 1'b1;
            end
        end
        iw_valid <= 1'b0;
        repeat (6) @(posedge mclk);
        check(exp_q.size(), 0);
        check(nop_seen, nop_exp);
        close_out();
    end

    initial begin : watchdog
        #100000;
        err_total++;
        close_out();
    end
endmodule // itod_top_bench

bind itod_top itod_props i_itod_props (.mclk, .rst, .ce, .iw_valid, .iw_word, .iw_class,
    .cond_true, .pc_change, .extra_cycle, .skip_next_two, .iw_ready_q, .ex_valid_q,
    .ex_nop_q, .ex_lone_q, .ex_bad_q, .ex_cycles_q, .ex_instr_q, .ex_two_q, .ex_wb_reg_q,
    .ex_wb_en_q, .ex_wb_step_q, .ex_lit_ok_q, .ex_work_reg_q, .ex_mul_a_q, .ex_mul_b_q,
    .ex_dsp_ok_q);

`default_nettype wire
